// ===== verilog/codec_startup_power_sequencer.sv
// Purpose: power-on reset, clock start-up, power controls and control-pin muxing
// Assumes: all pins synchronous to sys_clk; control mode given by spiMode
// Notes: multiplier lock is modelled by a timer set from the mode bits
`timescale 1ns/10ps
`default_nettype none

module codec_startup_power_sequencer #(
	parameter int unsigned POR_CYC       = codec_seq_pkg::POR_CYC,
	parameter int unsigned LOCK_FRAC_CYC = codec_seq_pkg::LOCK_FRAC_CYC,
	parameter int unsigned LOCK_INT_CYC  = codec_seq_pkg::LOCK_INT_CYC,
	parameter int unsigned LOCK_HI_CYC   = codec_seq_pkg::LOCK_HI_CYC
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic spiMode,
	input  wire logic latchN,
	input  wire logic sclClkIn,
	input  wire logic addrSelData,
	input  wire logic sdaIn,
	input  wire logic i2cDriveLow,
	output logic      sdaOut,
	output logic      sdaEnN,
	output logic      i2cAddrSelectBit1,
	output logic      i2cSclRx,
	output logic      i2cSdaRx,
	output logic      porActive,
	output logic      coreClockRun,
	output logic      pllPowerOn,
	output logic      pllLocked,
	output logic      adcPowerOn,
	output logic      dacPowerOn,
	output logic      adcOsr128,
	output logic      dacOsr128,
	output logic      clkSrcPll,
	output logic [1:0] inFreqSel,
	output logic [2:0] sampleRateSel,
	output logic [1:0] serialFormat
);
	localparam int W = codec_seq_pkg::CNT_W;
	localparam logic [W-1:0] POR_LAST = W'(POR_CYC - 1);

	typedef struct packed {
		codec_seq_pkg::seq_e  seq;
		logic [W-1:0]         porCnt;
		logic [W-1:0]         lockCnt;
		codec_seq_pkg::regs_s rg;
		logic                 addrSel1;
		logic                 sclRx;
		logic                 sdaRx;
	} core_st_s;

	// Idle-high receive copies, so I2C logic sees no false edge out of reset
	localparam core_st_s ST_RST = '{
		seq:      codec_seq_pkg::SQ_POR,
		porCnt:   '0,
		lockCnt:  '0,
		rg:       codec_seq_pkg::RG_RST,
		addrSel1: 1'b0,
		sclRx:    1'b1,
		sdaRx:    1'b1
	};

	core_st_s               st_r;
	core_st_s               st_nxt;
	codec_seq_pkg::spi_ev_s ev;
	logic                   portDout;
	logic                   portReadAct;
	logic [7:0]             rdData;
	logic [W-1:0]           lockTgt;
	logic                   runOk;
	logic                   isRun;

	// --------------------------------------------------
	// Register decode
	// --------------------------------------------------
	function automatic logic reachable(input logic [15:0] a, input logic run);
		// Other registers need the core clock; touching them early corrupts them
		reachable = run || a == codec_seq_pkg::ADDR_CLK || a == codec_seq_pkg::ADDR_PLL; // [R13]
	endfunction

	function automatic logic [7:0] regRead(input codec_seq_pkg::regs_s rg, input logic [15:0] a);
		case (a)
			codec_seq_pkg::ADDR_CLK:   regRead = rg.clk;
			codec_seq_pkg::ADDR_PLL:   regRead = rg.pll;
			codec_seq_pkg::ADDR_SPORT: regRead = rg.sport;
			codec_seq_pkg::ADDR_CONV:  regRead = rg.conv;
			codec_seq_pkg::ADDR_PWR:   regRead = rg.pwr;
			default:                   regRead = 8'h00;
		endcase
	endfunction

	assign isRun = st_r.seq == codec_seq_pkg::SQ_RUN;
	assign rdData = reachable(ev.addr, isRun) ? regRead(st_r.rg, ev.addr) : 8'h00; // [R13]

	spi_ctrl_port u_port (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.en      (spiMode && !porActive), // [R15]
		.latchN  (latchN),
		.spiClk  (sclClkIn),
		.din     (addrSelData), // [R10]
		.rdData  (rdData),
		.ev      (ev),
		.dout    (portDout),
		.readAct (portReadAct)
	);

	// --------------------------------------------------
	// Next state
	// --------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		lockTgt = W'(LOCK_FRAC_CYC);
		runOk = 1'b0;
		// Shared pins: address bit 1 and I2C lines only in I2C mode
		st_nxt.addrSel1 = spiMode ? 1'b0 : addrSelData; // [R10]
		st_nxt.sclRx = spiMode ? 1'b1 : sclClkIn; // [R9]
		st_nxt.sdaRx = spiMode ? 1'b1 : sdaIn; // [R9]
		if (st_r.seq == codec_seq_pkg::SQ_POR)
		begin
			st_nxt.rg = codec_seq_pkg::RG_RST; // [R1]
			st_nxt.lockCnt = '0;
			st_nxt.porCnt = st_r.porCnt + W'(1);
			if (st_r.porCnt == POR_LAST)
				st_nxt.seq = codec_seq_pkg::SQ_STOP; // [R2]
		end
		else
		begin
			if (ev.wr && reachable(ev.addr, isRun)) // [R13] [R3]
			begin
				case (ev.addr)
					codec_seq_pkg::ADDR_CLK:
					begin
						st_nxt.rg.clk = {4'h0, ev.data[3:0]};
						// Multiplier output is always 1024 fs
						if (ev.data[codec_seq_pkg::CLK_SRC])
							st_nxt.rg.clk[2:1] = codec_seq_pkg::INFREQ_1024; // [R11]
					end
					codec_seq_pkg::ADDR_PLL:
					begin
						st_nxt.rg.pll = {4'h0, ev.data[3:2], st_r.rg.pll[1], ev.data[0]};
					end
					codec_seq_pkg::ADDR_SPORT: st_nxt.rg.sport = {6'h00, ev.data[1:0]}; // [R12]
					codec_seq_pkg::ADDR_CONV:  st_nxt.rg.conv = {5'h00, ev.data[2:0]}; // [R11]
					codec_seq_pkg::ADDR_PWR:   st_nxt.rg.pwr = {4'h0, ev.data[3:0]}; // [R5] [R6]
					default: st_nxt.rg = st_r.rg;
				endcase
			end
			// Lock timer picks its length from mode and reference bits
			if (!st_r.rg.pll[codec_seq_pkg::PLL_TYPE])
				lockTgt = W'(LOCK_INT_CYC); // [R4]
			else if (st_r.rg.pll[codec_seq_pkg::PLL_HIREF])
				lockTgt = W'(LOCK_HI_CYC); // [R4]
			if (!st_nxt.rg.pll[codec_seq_pkg::PLL_EN])
			begin
				st_nxt.lockCnt = '0;
				st_nxt.rg.pll[codec_seq_pkg::PLL_LOCK] = 1'b0;
			end
			else if (!st_r.rg.pll[codec_seq_pkg::PLL_LOCK])
			begin
				if (st_r.lockCnt == lockTgt - W'(1))
					st_nxt.rg.pll[codec_seq_pkg::PLL_LOCK] = 1'b1; // [R4]
				else
					st_nxt.lockCnt = st_r.lockCnt + W'(1);
			end
			runOk = st_nxt.rg.clk[codec_seq_pkg::CLK_CORE_EN] &&
				(!st_nxt.rg.clk[codec_seq_pkg::CLK_SRC] ||
				st_nxt.rg.pll[codec_seq_pkg::PLL_LOCK]); // [R14]
			case (st_r.seq)
				codec_seq_pkg::SQ_STOP,
				codec_seq_pkg::SQ_LOCK,
				codec_seq_pkg::SQ_RUN:
				begin
					if (runOk)
						st_nxt.seq = codec_seq_pkg::SQ_RUN;
					else if (st_nxt.rg.clk[codec_seq_pkg::CLK_SRC] && st_nxt.rg.pll[codec_seq_pkg::PLL_EN])
						st_nxt.seq = codec_seq_pkg::SQ_LOCK;
					else
						st_nxt.seq = codec_seq_pkg::SQ_STOP;
				end
				default: st_nxt.seq = codec_seq_pkg::SQ_POR;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_r <= ST_RST;
		else
			st_r <= st_nxt;
	end

	// --------------------------------------------------
	// Outputs
	// --------------------------------------------------
	assign porActive = st_r.seq == codec_seq_pkg::SQ_POR;
	assign coreClockRun = isRun; // [R14]
	// Open-drain in I2C mode: only ever pulls low
	assign sdaOut = spiMode ? portDout : 1'b0; // [R9] [R10]
	assign sdaEnN = spiMode ? ~portReadAct : ~i2cDriveLow; // [R7] [R9]
	assign i2cAddrSelectBit1 = st_r.addrSel1;
	assign i2cSclRx = st_r.sclRx;
	assign i2cSdaRx = st_r.sdaRx;
	assign pllPowerOn = st_r.rg.pll[codec_seq_pkg::PLL_EN]; // [R5]
	assign pllLocked = st_r.rg.pll[codec_seq_pkg::PLL_LOCK];
	assign adcPowerOn = st_r.rg.pwr[codec_seq_pkg::PWR_ADC]; // [R5]
	assign dacPowerOn = st_r.rg.pwr[codec_seq_pkg::PWR_DAC]; // [R5]
	assign adcOsr128 = ~st_r.rg.pwr[codec_seq_pkg::PWR_ADC_O64]; // [R6]
	assign dacOsr128 = ~st_r.rg.pwr[codec_seq_pkg::PWR_DAC_O64]; // [R6]
	assign clkSrcPll = st_r.rg.clk[codec_seq_pkg::CLK_SRC];
	assign inFreqSel = st_r.rg.clk[2:1]; // [R11]
	assign sampleRateSel = st_r.rg.conv[2:0]; // [R11]
	assign serialFormat = st_r.rg.sport[1:0]; // [R12]

	// --------------------------------------------------
	// Checks
	// --------------------------------------------------
	int unsigned porSeen;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			porSeen <= 0;
		else if (porActive)
			porSeen <= porSeen + 1;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	por_defaults_a: assert property ( // [R1]
		porActive |-> st_r.rg == codec_seq_pkg::RG_RST && !coreClockRun)
		else $error("registers not at defaults during power-on reset");
	por_length_a: assert property ( // [R2]
		$fell(porActive) |-> porSeen == POR_CYC)
		else $error("power-on reset length wrong");
	lock_time_a: assert property ( // [R4]
		$rose(pllLocked) |-> $past(st_r.lockCnt) == $past(lockTgt) - W'(1) && pllPowerOn)
		else $error("lock flag rose at wrong count");
	pwr_indep_a: assert property ( // [R5]
		ev.wr && ev.addr == codec_seq_pkg::ADDR_PWR && isRun |=>
		adcPowerOn == $past(ev.data[0]) && dacPowerOn == $past(ev.data[1]))
		else $error("converter power not taken from write");
	osr_default_a: assert property ( // [R6]
		porActive |=> adcOsr128 && dacOsr128)
		else $error("oversampling default not 128x");
	readback_float_a: assert property ( // [R7]
		spiMode && latchN ##1 spiMode |-> sdaEnN)
		else $error("read-back pin driven outside a read");
	i2c_sda_a: assert property ( // [R9]
		!spiMode |-> !sdaOut && sdaEnN == !i2cDriveLow)
		else $error("I2C data pin not open-collector");
	pin_dual_a: assert property ( // [R10]
		!spiMode ##1 !spiMode |-> i2cAddrSelectBit1 == $past(addrSelData))
		else $error("address bit 1 not passed in I2C mode");
	infreq_pll_a: assert property ( // [R11]
		!porActive && clkSrcPll |-> inFreqSel == codec_seq_pkg::INFREQ_1024)
		else $error("multiplier source without 1024 fs");
	access_gate_a: assert property ( // [R13]
		ev.wr && ev.addr == codec_seq_pkg::ADDR_PWR && !isRun |=> $stable(st_r.rg.pwr))
		else $error("gated register written before run");
	core_stop_a: assert property ( // [R14]
		!st_r.rg.clk[codec_seq_pkg::CLK_CORE_EN] |-> ##[0:1] !coreClockRun)
		else $error("core clock running without enable");
	por_quiet_a: assert property ( // [R15]
		porActive |-> sdaEnN || !spiMode)
		else $error("read-back pin driven during reset");
	lock_drop_a: assert property ( // [R5]
		!pllPowerOn |-> !pllLocked)
		else $error("lock flag set with multiplier off");
	// Lock bit is read-only, so rewriting the enable must not drop it
	lock_ro_a: assert property ( // [R13]
		pllLocked && ev.wr && ev.addr == codec_seq_pkg::ADDR_PLL &&
		ev.data[codec_seq_pkg::PLL_EN] |=> pllLocked)
		else $error("lock flag changed by a write");
	run_lock_a: assert property ( // [R13]
		coreClockRun && clkSrcPll |-> pllLocked)
		else $error("core clock from unlocked multiplier");
	run_enable_a: assert property ( // [R14]
		coreClockRun |-> st_r.rg.clk[codec_seq_pkg::CLK_CORE_EN])
		else $error("core clock running with enable clear");
	read_gate_a: assert property ( // [R13]
		ev.rd && !isRun && ev.addr != codec_seq_pkg::ADDR_CLK && ev.addr != codec_seq_pkg::ADDR_PLL
		|=> !portDout)
		else $error("gated register read back before run");
	spi_pins_a: assert property ( // [R10]
		spiMode ##1 spiMode |-> i2cSclRx && i2cSdaRx && !i2cAddrSelectBit1)
		else $error("I2C receive copies not idle in SPI mode");
	sda_rx_a: assert property ( // [R9]
		!spiMode ##1 !spiMode |-> i2cSdaRx == $past(sdaIn) && i2cSclRx == $past(sclClkIn))
		else $error("I2C lines not received as inputs");
	por_no_event_a: assert property ( // [R15]
		porActive |-> !ev.wr && !ev.rd)
		else $error("control port active during reset");

	// --------------------------------------------------
	// Coverage
	// --------------------------------------------------
	lock_seen_c: cover property ($rose(pllLocked) ##[1:20] coreClockRun);
	spi_read_c: cover property ($rose(portReadAct) ##[1:100] $fell(portReadAct)); // [R8]
	format_set_c: cover property (serialFormat == 2'h3); // [R12]
	pll_off_c: cover property ($fell(pllPowerOn)); // [R5]
	i2c_drive_c: cover property (!spiMode && !sdaEnN); // [R9]
endmodule

`default_nettype wire

// ===== verilog/codec_seq_port.sv
// Purpose: shared constants and types, plus the SPI control port shifter
// Assumes: SPI pins already synchronous to sys_clk; SPI clock at most 10 MHz
// Notes: the SPI byte stream is chip byte, address high, address low, then data
//
// Functional notes
// [R1] Power-up resets every control register to its default before any access is taken.
// [R2] The internal power-on reset lasts about 14 ms and no transaction is taken before it ends.
// [R3] The host supplies power, locks the multiplier if used, enables the core clock, then writes settings.
// [R4] The multiplier reports lock after a mode and reference dependent time of 3.5, 2.96 or 2.4 ms.
// [R5] Record converters, playback converters and the multiplier power up and down independently.
// [R6] Each converter filter runs at 64x or 128x oversampling, 128x after reset.
// [R7] The SPI read-back pin is driven only during an active SPI read.
// [R8] The SPI clock may run freely or stop between transactions.
// [R9] In I2C mode the clock pin is input only and the data pin is an open-collector line.
// [R10] The shared pins carry address bit 1 or SPI data in, and I2C data or SPI read-back.
// [R11] The base sample rate follows the input clock selection and is scaled by the converter setting.
// [R12] The serial audio port offers I2S, left-justified, right-justified and TDM framing.
// [R13] Before core clock enable and lock, only the clock and multiplier registers are reachable.
// [R14] The core clock stays stopped until the host sets the core clock enable bit.
// [R15] During power-on reset the control port is ignored and the read-back pin floats.
`timescale 1ns/10ps
`default_nettype none

package codec_seq_pkg;
	localparam int unsigned SYS_CLK_HZ    = 50_000_000;
	localparam int unsigned CLK_NS        = 1_000_000_000 / SYS_CLK_HZ;
	localparam int unsigned POR_NS        = 14_000_000;
	localparam int unsigned LOCK_FRAC_NS  = 3_500_000;
	localparam int unsigned LOCK_INT_NS   = 2_960_000;
	localparam int unsigned LOCK_HIREF_NS = 2_400_000;
	localparam int unsigned POR_CYC       = (POR_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned LOCK_FRAC_CYC = (LOCK_FRAC_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned LOCK_INT_CYC  = (LOCK_INT_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned LOCK_HI_CYC   = (LOCK_HIREF_NS + CLK_NS - 1) / CLK_NS;
	localparam int          CNT_W         = 20;

	localparam logic [15:0] ADDR_CLK   = 16'h4000;
	localparam logic [15:0] ADDR_PLL   = 16'h4002;
	localparam logic [15:0] ADDR_SPORT = 16'h4015;
	localparam logic [15:0] ADDR_CONV  = 16'h4017;
	localparam logic [15:0] ADDR_PWR   = 16'h4019;

	localparam int CLK_CORE_EN = 0;
	localparam int CLK_INFREQ  = 1;
	localparam int CLK_SRC     = 3;
	localparam int PLL_EN      = 0;
	localparam int PLL_LOCK    = 1;
	localparam int PLL_TYPE    = 2;
	localparam int PLL_HIREF   = 3;
	localparam int PWR_ADC     = 0;
	localparam int PWR_DAC     = 1;
	localparam int PWR_ADC_O64 = 2;
	localparam int PWR_DAC_O64 = 3;

	localparam logic [7:0] CLK_RST   = 8'h00;
	localparam logic [7:0] PLL_RST   = 8'h00;
	localparam logic [7:0] SPORT_RST = 8'h00;
	localparam logic [7:0] CONV_RST  = 8'h00;
	localparam logic [7:0] PWR_RST   = 8'h00;
	localparam logic [1:0] INFREQ_1024 = 2'h3;

	localparam logic [4:0] HDR_LAST  = 5'h17;
	localparam logic [4:0] BYTE_LAST = 5'h07;
	localparam int         RW_BIT    = 16;

	typedef enum logic {PH_HDR, PH_DATA} spi_phase_e;
	typedef enum logic [1:0] {SQ_POR, SQ_STOP, SQ_LOCK, SQ_RUN} seq_e;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  data;
	} spi_ev_s;

	typedef struct packed {
		spi_phase_e  ph;
		logic        clkPrev;
		logic [4:0]  cnt;
		logic [23:0] sh;
		logic [15:0] addr;
		logic        rw;
		logic [7:0]  outSh;
		logic        readAct;
		spi_ev_s     ev;
	} spi_st_s;

	typedef struct packed {
		logic [7:0] clk;
		logic [7:0] pll;
		logic [7:0] sport;
		logic [7:0] conv;
		logic [7:0] pwr;
	} regs_s;

	localparam regs_s RG_RST = '{CLK_RST, PLL_RST, SPORT_RST, CONV_RST, PWR_RST};
endpackage

module spi_ctrl_port (
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic              en,
	input  wire logic              latchN,
	input  wire logic              spiClk,
	input  wire logic              din,
	input  wire logic [7:0]        rdData,
	output codec_seq_pkg::spi_ev_s ev,
	output logic                   dout,
	output logic                   readAct
);
	codec_seq_pkg::spi_st_s st_r;
	codec_seq_pkg::spi_st_s st_nxt;
	logic                   rise;
	logic                   fall;
	logic [23:0]            full;

	// --------------------------------------------------
	// Edge-driven shifter
	// --------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ev.wr = 1'b0;
		st_nxt.ev.rd = 1'b0;
		st_nxt.clkPrev = spiClk;
		// Edges seen only as sampled levels, so a parked clock is harmless
		rise = spiClk & ~st_r.clkPrev; // [R8]
		fall = ~spiClk & st_r.clkPrev; // [R8]
		full = {st_r.sh[22:0], din};
		if (st_r.ev.rd)
		begin
			st_nxt.outSh = rdData;
			st_nxt.readAct = 1'b1; // [R7]
		end
		if (!en || latchN)
		begin
			st_nxt.ph = codec_seq_pkg::PH_HDR;
			st_nxt.cnt = 5'h00;
			st_nxt.readAct = 1'b0; // [R7] [R15]
		end
		else if (rise)
		begin
			st_nxt.sh = full;
			st_nxt.cnt = st_r.cnt + 5'h01;
			case (st_r.ph)
				codec_seq_pkg::PH_HDR:
				begin
					if (st_r.cnt == codec_seq_pkg::HDR_LAST)
					begin
						st_nxt.ph = codec_seq_pkg::PH_DATA;
						st_nxt.cnt = 5'h00;
						st_nxt.rw = full[codec_seq_pkg::RW_BIT];
						st_nxt.addr = full[15:0];
						st_nxt.ev.addr = full[15:0];
						st_nxt.ev.rd = full[codec_seq_pkg::RW_BIT];
					end
				end
				codec_seq_pkg::PH_DATA:
				begin
					if (st_r.cnt == codec_seq_pkg::BYTE_LAST)
					begin
						st_nxt.cnt = 5'h00;
						st_nxt.addr = st_r.addr + 16'h0001;
						st_nxt.ev.addr = st_r.rw ? st_r.addr + 16'h0001 : st_r.addr;
						st_nxt.ev.wr = ~st_r.rw;
						st_nxt.ev.rd = st_r.rw;
						st_nxt.ev.data = full[7:0];
					end
				end
				default: st_nxt.ph = codec_seq_pkg::PH_HDR;
			endcase
		end
		else if (fall && st_r.ph == codec_seq_pkg::PH_DATA && st_r.cnt != 5'h00)
		begin
			st_nxt.outSh = {st_r.outSh[6:0], 1'b0};
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign ev = st_r.ev;
	assign dout = st_r.outSh[7];
	assign readAct = st_r.readAct;
endmodule

`default_nettype wire

// ===== verif/spi_host_model.sv
// Purpose: host processor model on the SPI control port
// Assumes: pins change on the falling system clock edge
// Notes: SPI clock stands still low between frames; hp sets the half period
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
	input  wire logic  sys_clk,
	input  wire logic  pinData,
	output logic       latchN,
	output logic       spiClk,
	output logic       din,
	output logic [7:0] rdByte,
	output logic       rdDone
);
	int hp;

	initial
	begin
		latchN = 1'b1;
		spiClk = 1'b0;
		din    = 1'b0;
		rdByte = 8'h00;
		rdDone = 1'b0;
		hp     = 3;
	end

	task automatic bitOut(input logic b, output logic s);
		@(negedge sys_clk);
		din = b;
		repeat (hp - 1) @(negedge sys_clk);
		s      = pinData;
		spiClk = 1'b1;
		repeat (hp) @(negedge sys_clk);
		spiClk = 1'b0;
	endtask

	task automatic xfer(input logic rw, input logic [15:0] addr, input logic [7:0] wd, output logic [7:0] rd);
		logic [31:0] f;
		logic        s;
		f  = {7'h00, rw, addr, wd};
		rd = 8'h00;
		@(negedge sys_clk);
		latchN = 1'b0;
		for (int i = 31; i >= 0; i--)
		begin
			bitOut(f[i], s);
			if (i < 8) rd[i] = s;
		end
		@(negedge sys_clk);
		latchN = 1'b1;
		// Released data line must not keep its last level
		din    = ~din;
		rdByte = rd;
		rdDone = rw;
		@(negedge sys_clk);
		rdDone = 1'b0;
	endtask
endmodule

`default_nettype wire

// ===== verif/tb.sv
// Purpose: self-checking bench for the start-up sequencer
// Assumes: shortened reset and lock counts
// Notes: expected read values pass through a queue to a monitor
`timescale 1ns/10ps
`default_nettype none

module tb;
	localparam int unsigned POR   = 300;
	localparam int unsigned LFRAC = 40;
	localparam int unsigned LINT  = 30;
	localparam int unsigned LHI   = 20;
	logic       sys_clk, rst_n, spiMode, sclI2c, addrI2c, sdaPull, i2cDriveLow;
	logic       hostClk, hostDin, latchN, rdDone, sdaOut, sdaEnN;
	logic       i2cAddrSelectBit1, i2cSclRx, i2cSdaRx, porActive, coreClockRun, pllPowerOn, pllLocked;
	logic       adcPowerOn, dacPowerOn, adcOsr128, dacOsr128, clkSrcPll;
	logic [1:0] inFreqSel, serialFormat;
	logic [2:0] sampleRateSel, latchHist, r;
	logic [7:0] rdByte, v, e;
	logic [7:0] expQ[$];
	logic [7:0] modes[3] = '{8'h05, 8'h0D, 8'h01};
	int         waits[3] = '{LFRAC, LHI, LINT};
	int         fails, testsRun, floatBad, n;
	// Pull-up on the data line, far party may pull low
	wire logic       pin  = (sdaEnN ? 1'b1 : sdaOut) & ~sdaPull;
	wire logic [7:0] stat = {porActive, coreClockRun, pllPowerOn, pllLocked, adcPowerOn, dacPowerOn, adcOsr128, dacOsr128};
	wire logic [7:0] cfg  = {clkSrcPll, inFreqSel, sampleRateSel, serialFormat};

	codec_startup_power_sequencer #(.POR_CYC(POR), .LOCK_FRAC_CYC(LFRAC), .LOCK_INT_CYC(LINT), .LOCK_HI_CYC(LHI))
	i_codec_startup_power_sequencer (
		.sys_clk(sys_clk), .rst_n(rst_n), .spiMode(spiMode), .latchN(latchN),
		.sclClkIn(spiMode ? hostClk : sclI2c), .addrSelData(spiMode ? hostDin : addrI2c), .sdaIn(pin),
		.i2cDriveLow(i2cDriveLow), .sdaOut(sdaOut), .sdaEnN(sdaEnN), .i2cAddrSelectBit1(i2cAddrSelectBit1),
		.i2cSclRx(i2cSclRx), .i2cSdaRx(i2cSdaRx), .porActive(porActive), .coreClockRun(coreClockRun),
		.pllPowerOn(pllPowerOn), .pllLocked(pllLocked), .adcPowerOn(adcPowerOn), .dacPowerOn(dacPowerOn),
		.adcOsr128(adcOsr128), .dacOsr128(dacOsr128), .clkSrcPll(clkSrcPll), .inFreqSel(inFreqSel),
		.sampleRateSel(sampleRateSel), .serialFormat(serialFormat));

	spi_host_model i_spi_host_model (
		.sys_clk(sys_clk), .pinData(pin), .latchN(latchN), .spiClk(hostClk), .din(hostDin),
		.rdByte(rdByte), .rdDone(rdDone));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		testsRun++;
		if (got !== exp) fails++;
		if (got !== exp) $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
	endtask

	task automatic checkCount(input string what, input int exp, input int got);
		testsRun++;
		if (got != exp) fails++;
		if (got != exp) $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] x;
		i_spi_host_model.xfer(1'b0, a, d, x);
	endtask

	task automatic rdReg(input logic [15:0] a, input logic [7:0] ex);
		logic [7:0] x;
		expQ.push_back(ex);
		i_spi_host_model.xfer(1'b1, a, 8'h00, x);
	endtask

	task automatic lockTime(input logic [7:0] mode, input int exp);
		int k;
		k = 0;
		fork
			wr(codec_seq_pkg::ADDR_PLL, mode);
			begin
				@(posedge pllPowerOn);
				do
				begin
					@(negedge sys_clk);
					k++;
				end
				while (pllLocked !== 1'b1 && k < 400);
			end
		join
		checkCount("lock cycles", exp, k);
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, monitors, watchdog
	// ----------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	initial
	forever
	begin
		@(posedge rdDone);
		if (expQ.size() == 0) checkCount("unexpected read", 0, 1);
		else check("read data", expQ.pop_front(), rdByte);
	end

	// Read-back pin must float once the latch has been high a while
	always @(negedge sys_clk)
	begin
		latchHist = {latchHist[1:0], latchN};
		if (rst_n === 1'b1 && spiMode === 1'b1 && latchHist === 3'b111 && sdaEnN !== 1'b1) floatBad++;
	end

	initial
	begin
		repeat (40000) @(posedge sys_clk);
		checkCount("watchdog", 0, 1);
		results();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{rst_n, sclI2c, addrI2c, sdaPull, i2cDriveLow} = 5'b01000;
		spiMode   = 1'b1;
		latchHist = 3'b111;
		n         = 0;
		void'($urandom(32'h0469f975));
		repeat (4) @(negedge sys_clk);
		check("reset state", 8'h83, stat);
		check("reset config", 8'h00, cfg);
		check("spi mode pins", 8'h13, {3'h0, sdaEnN, 1'b0, i2cAddrSelectBit1, i2cSclRx, i2cSdaRx});
		rst_n = 1'b1;
		fork
			while (porActive === 1'b1 && n < 2000)
			begin
				@(negedge sys_clk);
				n++;
			end
			wr(codec_seq_pkg::ADDR_PWR, 8'h03);
		join
		checkCount("reset length", POR, n);
		check("ignored in reset", 8'h03, stat);
		done("power-on");
		wr(codec_seq_pkg::ADDR_PWR, 8'h03);
		check("refused before run", 8'h03, stat);
		rdReg(codec_seq_pkg::ADDR_PWR, 8'h00);
		wr(codec_seq_pkg::ADDR_CLK, 8'h04);
		rdReg(codec_seq_pkg::ADDR_CLK, 8'h04);
		check("clock config", 8'h40, cfg);
		done("start-up access");
		for (int i = 0; i < 3; i++)
		begin
			lockTime(modes[i], waits[i]);
			rdReg(codec_seq_pkg::ADDR_PLL, modes[i] | 8'h02);
			if (i < 2) wr(codec_seq_pkg::ADDR_PLL, 8'h00);
			if (i < 2) check("lock dropped", 8'h00, {7'h00, pllLocked});
		end
		done("multiplier lock");
		wr(codec_seq_pkg::ADDR_CLK, 8'h09);
		check("run state", 8'h73, stat);
		check("run config", 8'hE0, cfg);
		rdReg(codec_seq_pkg::ADDR_CLK, 8'h0F);
		done("core clock");
		for (int i = 0; i < 6; i++)
		begin
			v = (i == 0) ? 8'h0F : 8'($urandom_range(15));
			wr(codec_seq_pkg::ADDR_PWR, v);
			check("power bits", {4'h7, v[0], v[1], ~v[2], ~v[3]}, stat);
			rdReg(codec_seq_pkg::ADDR_PWR, v);
		end
		for (int i = 0; i < 4; i++)
		begin
			r = 3'($urandom_range(7));
			wr(codec_seq_pkg::ADDR_SPORT, 8'(i));
			wr(codec_seq_pkg::ADDR_CONV, {5'h00, r});
			check("format rate", {3'h7, r, i[1:0]}, cfg);
		end
		rdReg(16'h4016, 8'h00);
		i_spi_host_model.hp = 5;
		rdReg(codec_seq_pkg::ADDR_PWR, v);
		wr(codec_seq_pkg::ADDR_PLL, 8'h00);
		check("multiplier off", {4'h0, 2'b00, v[0], v[1]}, {4'h0, stat[5:2]});
		checkCount("read-back float", 0, floatBad);
		done("power and format");
		spiMode = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			v = 8'($urandom());
			@(negedge sys_clk);
			{sclI2c, addrI2c, sdaPull, i2cDriveLow} = v[3:0];
			@(negedge sys_clk);
			e = {3'h0, 1'b0, ~v[0], v[2], v[3], ~(v[1] | v[0])};
			check("i2c pins", e, {3'h0, sdaOut, sdaEnN, i2cAddrSelectBit1, i2cSclRx, i2cSdaRx});
		end
		done("i2c pins");
		results();
	end
endmodule

`default_nettype wire
